// ### hdl/fgf_pkg.sv
package fgf_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_CFG    = 5'h04;
  localparam logic [4:0] OFS_TOKEN  = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0c;

  // Control register bit positions (write-one pulses)
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT  = 1;

  // Configuration field positions
  localparam int CFG_ACT_LSB  = 0;
  localparam int CFG_MODE_LSB = 3;
  localparam int CFG_ONCE_BIT = 5;
  localparam int CFG_MASK_LSB = 8;

  // Status bit positions
  localparam int STA_RUN_BIT   = 0;
  localparam int STA_ERR_BIT   = 1;
  localparam int STA_UNLK_BIT  = 2;
  localparam int STA_FIRE_BIT  = 3;
  localparam int STA_DONE_BIT  = 4;

  // Reset values
  localparam logic [31:0] CFG_RST      = 32'h0000_0000;
  localparam logic [7:0]  TOKEN_RST    = 8'h0a;  // Ten seconds

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SEC_TIME_NS   = 1_000_000_000;
  localparam int SEC_CYCLES    = SEC_TIME_NS / CLK_PERIOD_NS;
  localparam logic [4:0] RETEST_SEC = 5'd30;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    ST_HALT = 4'b0001,
    ST_RUN  = 4'b0010,
    ST_DONE = 4'b0100,
    ST_ERR  = 4'b1000
  } state_e;

  typedef enum logic [2:0] {
    ACT_NONE        = 3'h0,
    ACT_FOLLOW      = 3'h1,
    ACT_NOT_FOLLOW  = 3'h2,
    ACT_RISE_UNLOCK = 3'h3,
    ACT_RISE_LOCK   = 3'h4,
    ACT_FALL_UNLOCK = 3'h5,
    ACT_FALL_LOCK   = 3'h6
  } action_e;

  typedef enum logic [1:0] {
    UM_TIMED   = 2'h0,
    UM_LATCHED = 2'h1,
    UM_FIRE    = 2'h2
  } umode_e;

endpackage

// ### hdl/pin_sync_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pin_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  modport sync (input raw, output level);
  modport user (output raw, input level);
endinterface
`default_nettype wire

// ### hdl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync
  import fgf_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic  clk,
  input wire logic  rst_n,
  pin_sync_if.sync  sif
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_s;

  sync_s q;
  sync_s d;

  // Three stages; a bit only moves once stages two and three agree
  always_comb begin
    d = q;
    d.s1 = sif.raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sif.level = q.lvl;

endmodule
`default_nettype wire

// ### hdl/floor_group_input_follower.sv
// Behaviour
// R1: Software halts the function before changing its type or settings.
// R2: Normal mode resumes running after a system restart if it was running.
// R3: Run-once mode acts once, then idles until stopped and started again.
// R4: Software must select an action; with none the function does nothing.
// R5: Follow: input on unlocks, off locks, input re-sampled every 30 seconds.
// R6: Test actions restore own state 30 seconds after an external change.
// R7: The restore delay applies only to changes the function did not cause.
// R8: Inverted follow: input on locks, off unlocks, same retest and restore.
// R9: Rising-edge unlock acts only on off-to-on; later changes are left alone.
// R10: Rising-edge lock acts only on off-to-on; later changes are left alone.
// R11: Falling-edge unlock acts only on on-to-off; later changes left alone.
// R12: Falling-edge inverted acts on on-to-off and drives the locked state.
// R13: Invalid primary input at start raises an error and suspends the function.
// R14: The floor group is driven identically on every elevator in the group.
// R15: An unlock lasts a programmable token time in seconds, default ten.
// R16: Timed mode unlocks for the token time, then locks automatically.
// R17: Latched mode keeps floors unlocked until another source commands otherwise.
// R18: Fire mode latches fire unlock; only a fire-cancel source releases it. The code also clears it on SYS_RESTART.
// R19: Primary input is synchronised; edges come from current versus previous sample.
`timescale 1ns/10ps
`default_nettype none
module floor_group_input_follower
  import fgf_pkg::*;
#(
  parameter int N_ELEV     = 8,
  parameter int SEC_CYC    = SEC_CYCLES,
  parameter int ADDR_W     = 5
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RST_N,
  // System restart that keeps the configuration
  input  wire logic              SYS_RESTART,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  // AXI4-Lite write response
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  // Asynchronous pins from the rest of the system
  input  wire logic              PRI_IN,
  input  wire logic              PRI_VALID,
  input  wire logic              OVR_STROBE,
  input  wire logic              OVR_UNLOCK,
  input  wire logic              FIRE_CANCEL,
  // Floor group drive and state
  output logic [N_ELEV-1:0]      ELEV_UNLOCK,
  output logic                   FIRE_ACTIVE,
  output logic                   FUNC_RUNNING,
  output logic                   FUNC_ERROR
);

  localparam int SEC_W = $clog2(SEC_CYC + 1);
  localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SEC_CYC - 1);
  localparam logic [31:0] CFG_WMASK =
    32'h0000_003f | (((32'h1 << N_ELEV) - 32'h1) << CFG_MASK_LSB);

  typedef struct packed {
    state_e              st;
    logic                awready;
    logic                wready;
    logic                aw_have;
    logic                w_have;
    logic [ADDR_W-1:0]   awaddr;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
    logic [31:0]         cfg;
    logic [7:0]          token;
    logic                err;
    logic [SEC_W-1:0]    sec_cnt;
    logic [4:0]          retest_cnt;
    logic [4:0]          hold_cnt;
    logic [7:0]          token_cnt;
    logic                token_run;
    logic                first;
    logic                pri_prev;
    logic                ovr_prev;
    logic                fcan_prev;
    logic                unlock;
    logic                fire;
    logic [N_ELEV-1:0]   out;
  } state_s;

  state_s q;
  state_s d;

  pin_sync_if #(.W(5)) psif ();

  logic              pri;
  logic              pri_ok;
  logic              ovr_lvl;
  logic              ovr_val;
  logic              fcan_lvl;
  logic              sec_tick;
  logic              rise;
  logic              fall;
  logic              ovr_evt;
  logic              fcan_evt;
  logic              wr_go;
  logic              start_req;
  logic              stop_req;
  logic              want;
  logic              act_unlock;
  logic              act_lock;
  logic              test_act;
  logic [31:0]       wmerge;
  logic [31:0]       status;
  action_e           action;
  umode_e            umode;

  // Every pin crosses four flops before the logic sees it
  // R19: primary input sync
  assign psif.raw = {FIRE_CANCEL, OVR_UNLOCK, OVR_STROBE, PRI_VALID, PRI_IN};

  pin_sync #(.W(5)) u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .sif   (psif)
  );

  assign pri      = psif.level[0];
  assign pri_ok   = psif.level[1];
  assign ovr_lvl  = psif.level[2];
  assign ovr_val  = psif.level[3];
  assign fcan_lvl = psif.level[4];

  assign action = action_e'(q.cfg[CFG_ACT_LSB +: 3]);
  assign umode  = umode_e'(q.cfg[CFG_MODE_LSB +: 2]);

  // Read-back view of the function state
  always_comb begin
    status = 32'h0;
    status[STA_RUN_BIT]  = (q.st == ST_RUN);
    status[STA_ERR_BIT]  = q.err;
    status[STA_UNLK_BIT] = q.unlock;
    status[STA_FIRE_BIT] = q.fire;
    status[STA_DONE_BIT] = (q.st == ST_DONE);
  end

  // Byte-lane merge of write data into the configuration word
  always_comb begin
    wmerge = q.cfg;
    for (int i = 0; i < 4; i++) begin
      if (q.wstrb[i]) begin
        wmerge[i*8 +: 8] = q.wdata[i*8 +: 8];
      end
    end
  end

  // Event decode; edges compare this sample with the previous one
  // R19: edge detection
  always_comb begin
    sec_tick  = (q.sec_cnt == SEC_LAST);
    rise      = pri && !q.pri_prev;
    fall      = !pri && q.pri_prev;
    ovr_evt   = ovr_lvl && !q.ovr_prev;
    fcan_evt  = fcan_lvl && !q.fcan_prev;
    wr_go     = q.aw_have && q.w_have && !q.bvalid;
    start_req = wr_go && (q.awaddr == OFS_CTRL) && q.wstrb[0] && q.wdata[CTRL_START_BIT];
    stop_req  = wr_go && (q.awaddr == OFS_CTRL) && q.wstrb[0] && q.wdata[CTRL_STOP_BIT];
    test_act  = (action == ACT_FOLLOW) || (action == ACT_NOT_FOLLOW);
  end

  // Action selection while running
  always_comb begin
    want       = 1'b0;
    act_unlock = 1'b0;
    act_lock   = 1'b0;
    if (q.st == ST_RUN) begin
      case (action)
        // R5: follow input
        // R8: inverted follow
        ACT_FOLLOW, ACT_NOT_FOLLOW: begin
          want = pri ^ (action == ACT_NOT_FOLLOW);
          // R6: restore after hold expiry
          if (q.first || rise || fall ||
              (sec_tick && q.hold_cnt == 5'd1) ||
              (sec_tick && q.hold_cnt == 5'd0 && q.retest_cnt == 5'd1)) begin
            act_unlock = want;
            act_lock   = !want;
          end
        end
        // R9: rising edge unlock
        ACT_RISE_UNLOCK: begin
          act_unlock = rise;
        end
        // R10: rising edge lock
        ACT_RISE_LOCK: begin
          act_lock = rise;
        end
        // R11: falling edge unlock
        ACT_FALL_UNLOCK: begin
          act_unlock = fall;
        end
        // R12: falling edge lock
        ACT_FALL_LOCK: begin
          act_lock = fall;
        end
        // R4: no action selected
        default: begin
          act_unlock = 1'b0;
        end
      endcase
    end
  end

  // Next-state logic for bus, counters and floor group
  always_comb begin
    d = q;
    d.pri_prev  = pri;
    d.ovr_prev  = ovr_lvl;
    d.fcan_prev = fcan_lvl;
    d.first     = 1'b0;
    d.sec_cnt   = sec_tick ? '0 : q.sec_cnt + SEC_W'(1);

    // Address and data are taken independently, in either order
    if (AWVALID && q.awready) begin
      d.awaddr  = AWADDR;
      d.aw_have = 1'b1;
      d.awready = 1'b0;
    end
    if (WVALID && q.wready) begin
      d.wdata  = WDATA;
      d.wstrb  = WSTRB;
      d.w_have = 1'b1;
      d.wready = 1'b0;
    end
    if (wr_go) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      case (q.awaddr)
        OFS_CTRL: begin
          d.bresp = RESP_OKAY;
        end
        // Settings are frozen unless the function is halted or in error
        OFS_CFG: begin
          if (q.st == ST_HALT || q.st == ST_ERR) begin
            d.cfg = wmerge & CFG_WMASK;
          end
        end
        OFS_TOKEN: begin
          if ((q.st == ST_HALT || q.st == ST_ERR) && q.wstrb[0]) begin
            d.token = q.wdata[7:0];
          end
        end
        OFS_STATUS: begin
          d.bresp = RESP_OKAY;
        end
        default: begin
          d.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.bvalid && BREADY) begin
      d.bvalid  = 1'b0;
      d.awready = 1'b1;
      d.wready  = 1'b1;
    end

    // Read channel answers one cycle after the address is taken
    if (ARVALID && q.arready) begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rresp   = RESP_OKAY;
      case (ARADDR)
        OFS_CTRL:   d.rdata = 32'h0;
        OFS_CFG:    d.rdata = q.cfg;
        OFS_TOKEN:  d.rdata = {24'h0, q.token};
        OFS_STATUS: d.rdata = status;
        default: begin
          d.rdata = 32'h0;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.rvalid && RREADY) begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end

    // Retest and hold counters, in seconds
    if (sec_tick && q.hold_cnt != 5'd0) begin
      d.hold_cnt = q.hold_cnt - 5'd1;
    end
    if (sec_tick && q.st == ST_RUN) begin
      d.retest_cnt = (q.retest_cnt <= 5'd1) ? RETEST_SEC : q.retest_cnt - 5'd1;
    end

    // R16: lock at token expiry
    if (q.token_run && sec_tick) begin
      if (q.token_cnt <= 8'd1) begin
        d.token_run = 1'b0;
        d.unlock    = 1'b0;
      end else begin
        d.token_cnt = q.token_cnt - 8'd1;
      end
    end

    // Another source changes the group; fire unlock cannot be overridden
    // R17: latch released externally
    if (ovr_evt && !q.fire) begin
      d.unlock    = ovr_val;
      d.token_run = 1'b0;
      // R7: only foreign changes held
      if (test_act && q.st == ST_RUN && ovr_val != q.unlock) begin
        d.hold_cnt = RETEST_SEC + 5'd1;
      end
    end

    // R18: fire released by cancel
    if (fcan_evt) begin
      d.fire = 1'b0;
    end

    // Own action wins over a simultaneous foreign change
    if (act_unlock) begin
      d.unlock    = 1'b1;
      d.token_run = 1'b0;
      d.hold_cnt  = 5'd0;
      d.retest_cnt = RETEST_SEC;
      case (umode)
        // R15: token time load
        UM_TIMED: begin
          d.token_run = 1'b1;
          d.token_cnt = q.token;
        end
        // R18: fire unlock latch
        UM_FIRE: begin
          d.fire = 1'b1;
        end
        default: begin
          d.token_run = 1'b0;
        end
      endcase
    end
    if (act_lock) begin
      d.unlock     = 1'b0;
      d.token_run  = 1'b0;
      d.hold_cnt   = 5'd0;
      d.retest_cnt = RETEST_SEC;
    end

    // R3: single run then idle
    if ((act_unlock || act_lock) && q.cfg[CFG_ONCE_BIT]) begin
      d.st = ST_DONE;
    end

    // Function control
    case (q.st)
      ST_HALT, ST_ERR: begin
        if (start_req) begin
          // R13: invalid input suspends
          if (!pri_ok) begin
            d.st  = ST_ERR;
            d.err = 1'b1;
          end else begin
            d.st         = ST_RUN;
            d.err        = 1'b0;
            d.first      = 1'b1;
            d.retest_cnt = RETEST_SEC;
          end
        end
      end
      ST_RUN, ST_DONE: begin
        if (stop_req) begin
          d.st        = ST_HALT;
          d.token_run = 1'b0;
          d.hold_cnt  = 5'd0;
        end
      end
      default: begin
        d.st = ST_HALT;
      end
    endcase

    // R2: resume after restart
    if (SYS_RESTART) begin
      d.st        = (q.st == ST_RUN && !q.cfg[CFG_ONCE_BIT]) ? ST_RUN : ST_HALT;
      d.first     = (q.st == ST_RUN && !q.cfg[CFG_ONCE_BIT]);
      d.unlock    = 1'b0;
      d.fire      = 1'b0;
      d.token_run = 1'b0;
      d.hold_cnt  = 5'd0;
      d.retest_cnt = RETEST_SEC;
    end

    // R14: same drive on every member elevator
    d.out = (d.unlock || d.fire) ? d.cfg[CFG_MASK_LSB +: N_ELEV] : '0;
  end

  // Single register bank for the whole block apart from the pin synchroniser flops in u_sync
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      q            <= '0;
      q.st         <= ST_HALT;
      q.awready    <= 1'b1;
      q.wready     <= 1'b1;
      q.arready    <= 1'b1;
      q.cfg        <= CFG_RST;
      q.token      <= TOKEN_RST;
      q.retest_cnt <= RETEST_SEC;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the register bank; FUNC_RUNNING is decoded from q.st
  assign AWREADY      = q.awready;
  assign WREADY       = q.wready;
  assign BVALID       = q.bvalid;
  assign BRESP        = q.bresp;
  assign ARREADY      = q.arready;
  assign RVALID       = q.rvalid;
  assign RRESP        = q.rresp;
  assign RDATA        = q.rdata;
  assign ELEV_UNLOCK  = q.out;
  assign FIRE_ACTIVE  = q.fire;
  assign FUNC_RUNNING = (q.st == ST_RUN);
  assign FUNC_ERROR   = q.err;

endmodule
`default_nettype wire

// ### tb/floor_source.sv
`timescale 1ns/10ps
`default_nettype none
module floor_source (
  // Clock
  input  wire logic clk,
  // Requests from the bench
  input  wire logic req_set,
  input  wire logic req_unlock,
  input  wire logic req_cancel,
  // Pins towards the function
  output logic      ovr_strobe,
  output logic      ovr_unlock,
  output logic      fire_cancel
);
  logic [3:0] set_q = 4'h0;
  logic [3:0] can_q = 4'h0;
  // foreign floor command
  // Pulses last eight cycles so the pin filter always sees them
  always @(posedge clk) begin
    if (req_set) begin
      set_q <= 4'h8;
      ovr_unlock <= req_unlock;
    end else if (set_q != 4'h0) begin
      set_q <= set_q - 4'h1;
    end else begin
      ovr_unlock <= ~ovr_unlock; // Level toggles every cycle outside a strobe
    end
  end
  always @(posedge clk) begin
    if (req_cancel) begin
      can_q <= 4'h8;
    end else if (can_q != 4'h0) begin
      can_q <= can_q - 4'h1;
    end
  end
  assign ovr_strobe  = set_q != 4'h0;
  assign fire_cancel = can_q != 4'h0;
  initial ovr_unlock = 1'b0;
endmodule
`default_nettype wire

// ### tb/fgf_properties.sv
`timescale 1ns/10ps
`default_nettype none
module fgf_properties
  import fgf_pkg::*;
#(
  parameter int N_ELEV = 8,
  parameter int ADDR_W = 5
) (
  // Clock and reset
  input wire logic              CLK,
  input wire logic              RST_N,
  input wire logic              SYS_RESTART,
  // Register bus
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic              AWVALID,
  input wire logic              AWREADY,
  input wire logic              WVALID,
  input wire logic              WREADY,
  input wire logic [1:0]        BRESP,
  input wire logic              BVALID,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic              ARVALID,
  input wire logic              ARREADY,
  input wire logic [31:0]       RDATA,
  input wire logic [1:0]        RRESP,
  input wire logic              RVALID,
  // Function pins
  input wire logic              FIRE_CANCEL,
  input wire logic [N_ELEV-1:0] ELEV_UNLOCK,
  input wire logic              FIRE_ACTIVE,
  input wire logic              FUNC_RUNNING,
  input wire logic              FUNC_ERROR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_reset_idle;
    $rose(RST_N) |-> AWREADY && WREADY && ARREADY && !BVALID && !RVALID && !FUNC_RUNNING && ELEV_UNLOCK == '0;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("bus not idle after reset");
  property p_wr_refuse;
    $rose(BVALID) |-> !AWREADY && !WREADY;
  endproperty
  a_wr_refuse: assert property (p_wr_refuse) else $error("write accepted while answering");
  property p_wr_unmapped;
    AWVALID && AWREADY && WVALID && WREADY && AWADDR >= 16 |-> ##[1:3] (BVALID && BRESP == RESP_SLVERR);
  endproperty
  a_wr_unmapped: assert property (p_wr_unmapped) else $error("unmapped write not refused");
  property p_rd_answer;
    ARVALID && ARREADY |=> RVALID && !ARREADY;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_unmapped;
    ARVALID && ARREADY && ARADDR >= 16 |=> RRESP == RESP_SLVERR && RDATA == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");
  property p_err_start;
    $rose(FUNC_ERROR) |-> $rose(BVALID);
  endproperty
  a_err_start: assert property (p_err_start) else $error("error without a start");
  property p_err_susp;
    FUNC_ERROR |-> !FUNC_RUNNING;
  endproperty
  a_err_susp: assert property (p_err_susp) else $error("running while in error");
  property p_run_start;
    $rose(FUNC_RUNNING) |-> $rose(BVALID);
  endproperty
  a_run_start: assert property (p_run_start) else $error("run without a start");
  property p_fire_hold;
    $fell(FIRE_ACTIVE) |-> $past(FIRE_CANCEL, 3) || $past(FIRE_CANCEL, 4) || $past(FIRE_CANCEL, 5) || $past(SYS_RESTART);
  endproperty
  a_fire_hold: assert property (p_fire_hold) else $error("fire latch dropped");
endmodule
bind floor_group_input_follower fgf_properties #(.N_ELEV(N_ELEV), .ADDR_W(ADDR_W)) props (
  .CLK(CLK), .RST_N(RST_N), .SYS_RESTART(SYS_RESTART), .AWADDR(AWADDR), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
  .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
  .RVALID(RVALID), .FIRE_CANCEL(FIRE_CANCEL), .ELEV_UNLOCK(ELEV_UNLOCK),
  .FIRE_ACTIVE(FIRE_ACTIVE), .FUNC_RUNNING(FUNC_RUNNING), .FUNC_ERROR(FUNC_ERROR)
);
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import fgf_pkg::*;
  localparam int SEC = 20;
  localparam logic [7:0] MASK = 8'h5a;
  logic        clk, rst_n, sys_restart, awvalid, wvalid, bready, arvalid, rready, pri_in, pri_valid;
  logic        req_set, req_unlock, req_cancel, ovr_strobe, ovr_unlock, fire_cancel;
  logic        awready, wready, bvalid, arready, rvalid, fire_active, func_running, func_error;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_q;
  logic [1:0]  bresp, rresp, resp_q;
  logic [7:0]  elev_unlock;
  int          mismatches, checks;
  floor_group_input_follower #(.N_ELEV(8), .SEC_CYC(SEC), .ADDR_W(5)) dut (
    .CLK(clk), .RST_N(rst_n), .SYS_RESTART(sys_restart), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .PRI_IN(pri_in),
    .PRI_VALID(pri_valid), .OVR_STROBE(ovr_strobe), .OVR_UNLOCK(ovr_unlock), .FIRE_CANCEL(fire_cancel),
    .ELEV_UNLOCK(elev_unlock), .FIRE_ACTIVE(fire_active), .FUNC_RUNNING(func_running), .FUNC_ERROR(func_error)
  );
  floor_source src (
    .clk(clk), .req_set(req_set), .req_unlock(req_unlock), .req_cancel(req_cancel),
    .ovr_strobe(ovr_strobe), .ovr_unlock(ovr_unlock), .fire_cancel(fire_cancel)
  );
  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic wrap_up;
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Address and data offered together, each dropped once taken
  // Ready is looked at on the falling edge, where it is settled; the transfer is the next rising edge
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    logic aw_hit;
    logic w_hit;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done)) begin
      @(negedge clk);
      aw_hit = !aw_done && awready === 1'b1;
      w_hit = !w_done && wready === 1'b1;
      @(posedge clk);
      if (aw_hit) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (w_hit) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(negedge clk); while (bvalid !== 1'b1);
    resp_q = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(negedge clk); while (rvalid !== 1'b1);
    rd_q = rdata;
    resp_q = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic run(input logic [31:0] c);
    wr(OFS_CTRL, 32'h2);
    wr(OFS_CFG, c);
    wr(OFS_CTRL, 32'h1);
    cyc(8);
  endtask
  task automatic ovr(input logic v);
    req_set <= 1'b1;
    req_unlock <= v;
    @(posedge clk);
    req_set <= 1'b0;
    cyc(14);
  endtask
  task automatic pin(input logic v);
    pri_in <= v;
    cyc(8);
  endtask
  function automatic logic [31:0] cf(input action_e a, input umode_e m, input logic o);
    return {16'h0000, MASK, 2'b00, o, m, a};
  endfunction
  // Hang guard, well beyond the expected few thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    wrap_up;
  end
  initial begin
    logic idle;
    logic ex;
    {rst_n, sys_restart, awvalid, wvalid, bready, arvalid, rready, pri_in, pri_valid} = '0;
    {req_set, req_unlock, req_cancel, awaddr, araddr, wdata} = '0;
    mismatches = 0;
    checks = 0;
    cyc(8);
    rst_n <= 1'b1;
    rd(OFS_TOKEN);
    `CHK("token", 32'h0000000a, rd_q)
    rd(OFS_CFG);
    `CHK("cfg", CFG_RST, rd_q)
    rd(5'h14);
    `CHK("rresp", RESP_SLVERR, resp_q)
    wr(5'h10, 32'h1);
    `CHK("bresp", RESP_SLVERR, resp_q)
    run(cf(ACT_FOLLOW, UM_LATCHED, 1'b0));
    `CHK("error", 1'b1, func_error)
    rd(OFS_STATUS);
    `CHK("status", 32'h00000002, rd_q)
    pri_valid <= 1'b1;
    pin(1'b1);
    wr(OFS_CTRL, 32'h1);
    cyc(8);
    `CHK("running", 1'b1, func_running)
    `CHK("unlock", MASK, elev_unlock)
    wr(OFS_CFG, cf(ACT_NOT_FOLLOW, UM_LATCHED, 1'b0));
    rd(OFS_CFG);
    `CHK("cfg", cf(ACT_FOLLOW, UM_LATCHED, 1'b0), rd_q)
    pin(1'b0);
    `CHK("unlock", 8'h00, elev_unlock)
    pin(1'b1);
    ovr(1'b0);
    `CHK("unlock", 8'h00, elev_unlock)
    cyc(27 * SEC);
    `CHK("unlock", 8'h00, elev_unlock)
    cyc(5 * SEC);
    `CHK("unlock", MASK, elev_unlock)
    sys_restart <= 1'b1;
    @(posedge clk);
    sys_restart <= 1'b0;
    cyc(8);
    `CHK("running", 1'b1, func_running)
    cyc(31 * SEC);
    `CHK("unlock", MASK, elev_unlock)
    run(cf(ACT_NOT_FOLLOW, UM_LATCHED, 1'b0));
    `CHK("unlock", 8'h00, elev_unlock)
    pin(1'b0);
    `CHK("unlock", MASK, elev_unlock)
    // Each edge action: preset the opposite state, fire the edge, then tamper
    for (int i = 3; i <= 6; i++) begin
      idle = (i >= 5);
      ex = (i == 3 || i == 5);
      pin(idle);
      run(cf(action_e'(i), UM_LATCHED, 1'b0));
      ovr(!ex);
      pin(!idle);
      `CHK("edge act", (ex ? MASK : 8'h00), elev_unlock)
      ovr(!ex);
      pin(idle);
      cyc(35 * SEC);
      `CHK("edge hold", (ex ? 8'h00 : MASK), elev_unlock)
    end
    wr(OFS_CTRL, 32'h2);
    wr(OFS_TOKEN, 32'h3);
    pin(1'b0);
    run(cf(ACT_RISE_UNLOCK, UM_TIMED, 1'b0));
    ovr(1'b0);
    pin(1'b1);
    cyc(SEC);
    `CHK("timed", MASK, elev_unlock)
    cyc(3 * SEC);
    `CHK("timed", 8'h00, elev_unlock)
    pin(1'b0);
    run(cf(ACT_RISE_UNLOCK, UM_FIRE, 1'b0));
    pin(1'b1);
    `CHK("fire", 1'b1, fire_active)
    ovr(1'b0);
    `CHK("fire", MASK, elev_unlock)
    req_cancel <= 1'b1;
    @(posedge clk);
    req_cancel <= 1'b0;
    cyc(14);
    `CHK("fire", 1'b0, fire_active)
    ovr(1'b0);
    pin(1'b0);
    run(cf(ACT_RISE_UNLOCK, UM_LATCHED, 1'b1));
    pin(1'b1);
    rd(OFS_STATUS);
    `CHK("status", 32'h00000014, rd_q)
    ovr(1'b0);
    pin(1'b0);
    pin(1'b1);
    `CHK("once", 8'h00, elev_unlock)
    sys_restart <= 1'b1;
    @(posedge clk);
    sys_restart <= 1'b0;
    cyc(4);
    rd(OFS_STATUS);
    `CHK("status", 32'h00000000, rd_q)
    wr(OFS_CTRL, 32'h1);
    cyc(4);
    `CHK("running", 1'b1, func_running)
    wrap_up;
  end
endmodule
`default_nettype wire
